// ### rtl/dspt_pkg.sv
// Shared constants, register map and carrier types for the dual-slope PWM timer
package dspt_pkg;

    // Counter and bus widths
    localparam int CNT_W  = 16;
    localparam int AXI_AW = 8;
    localparam int AXI_DW = 32;

    // Register byte offsets on the AXI4-Lite slave
    localparam logic [AXI_AW-1:0] OFS_CTRL    = 8'h00;
    localparam logic [AXI_AW-1:0] OFS_COUNT   = 8'h04;
    localparam logic [AXI_AW-1:0] OFS_CMP_A   = 8'h08;
    localparam logic [AXI_AW-1:0] OFS_CMP_B   = 8'h0c;
    localparam logic [AXI_AW-1:0] OFS_CAPTURE = 8'h10;
    localparam logic [AXI_AW-1:0] OFS_FLAGS   = 8'h14;
    localparam logic [AXI_AW-1:0] OFS_STATUS  = 8'h18;

    // Counter end points
    localparam logic [CNT_W-1:0] BOTTOM    = 16'h0000;
    localparam logic [CNT_W-1:0] TOP_FIX8  = 16'h00ff;
    localparam logic [CNT_W-1:0] TOP_FIX9  = 16'h01ff;
    localparam logic [CNT_W-1:0] TOP_FIX10 = 16'h03ff;
    localparam logic [CNT_W-1:0] CNT_ONE   = 16'h0001;

    // Waveform mode select codes
    localparam logic [3:0] MODE_PC_FIX8  = 4'h1;
    localparam logic [3:0] MODE_PC_FIX9  = 4'h2;
    localparam logic [3:0] MODE_PC_FIX10 = 4'h3;
    localparam logic [3:0] MODE_PFC_CAP  = 4'h8;
    localparam logic [3:0] MODE_PFC_CMP  = 4'h9;
    localparam logic [3:0] MODE_PC_CAP   = 4'ha;
    localparam logic [3:0] MODE_PC_CMP   = 4'hb;

    // Output action select codes
    localparam logic [1:0] ACT_NONINV = 2'h2;
    localparam logic [1:0] ACT_INV    = 2'h3;

    // Clock select codes and prescaler tap widths
    localparam logic [2:0] CS_STOP    = 3'h0;
    localparam logic [2:0] CS_DIV1    = 3'h1;
    localparam logic [2:0] CS_DIV8    = 3'h2;
    localparam logic [2:0] CS_DIV64   = 3'h3;
    localparam logic [2:0] CS_DIV256  = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam int PRE_BITS8    = 3;
    localparam int PRE_BITS64   = 6;
    localparam int PRE_BITS256  = 8;
    localparam int PRE_BITS1024 = 10;

    // Flag bit positions
    localparam int FLAG_OVF  = 0;
    localparam int FLAG_CMPA = 1;
    localparam int FLAG_CMPB = 2;
    localparam int FLAG_CAP  = 3;
    localparam int FLAG_N    = 4;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Control register layout, bit 0 upward: mode, clock select, actions, pin directions
    typedef struct packed {
        logic [18:0]      unused;
        logic [1:0]       pinDir;
        logic [1:0][1:0]  outAction;
        logic [2:0]       clockSel;
        logic [3:0]       waveMode;
    } dspt_ctrl_type;

    localparam dspt_ctrl_type CTRL_RESET = '0;

    typedef struct packed {
        logic              awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic              wvalid;
        logic [AXI_DW-1:0] wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [AXI_AW-1:0] araddr;
        logic              rready;
    } dspt_axi_req_type;

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [AXI_DW-1:0] rdata;
        logic [1:0]        rresp;
    } dspt_axi_rsp_type;

endpackage

// ### rtl/dspt_prescaler.sv
// Prescaler that turns the I/O clock into a one-cycle timer tick enable
`timescale 1ns/10ps
module dspt_prescaler #(
    parameter int PRE_W = 10
) (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic [2:0] clockSel,
    output logic            timerTick
);

    typedef struct packed {
        logic [PRE_W-1:0] count;
    } dspt_pre_state_type;

    dspt_pre_state_type s_q;
    dspt_pre_state_type s_d;

    // The widest ratio needs the full divider
    if (PRE_W < dspt_pkg::PRE_BITS1024)
    begin : g_chk
        $error("dspt_prescaler: PRE_W too small for the largest ratio");
    end

    // Free-running divider; a tick marks the wrap of the selected tap
    always_comb
    begin
        s_d = s_q;
        s_d.count = s_q.count + {{(PRE_W-1){1'b0}}, 1'b1};
        unique case (clockSel)
            dspt_pkg::CS_DIV1:    timerTick = 1'b1;
            dspt_pkg::CS_DIV8:    timerTick = &s_q.count[dspt_pkg::PRE_BITS8-1:0];
            dspt_pkg::CS_DIV64:   timerTick = &s_q.count[dspt_pkg::PRE_BITS64-1:0];
            dspt_pkg::CS_DIV256:  timerTick = &s_q.count[dspt_pkg::PRE_BITS256-1:0];
            dspt_pkg::CS_DIV1024: timerTick = &s_q.count[dspt_pkg::PRE_BITS1024-1:0];
            default:              timerTick = 1'b0;
        endcase
    end

    // Synchronous reset; no second clock, the tick is only an enable
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

endmodule

// ### rtl/dspt_timer.sv
// Dual-slope PWM timer with AXI4-Lite register access and two compare outputs
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
// Behaviour
// - Phase correct mode loads active compares from buffers at TOP.
// - Action two gives non-inverted PWM, three gives inverted PWM.
// - Waveform reaches the pin only when its direction bit selects output.
// - Non-inverting clears on up-count match, sets on down-count match; inverting opposite.
// - Timer tick is the clock divided by 1, 8, 64, 256 or 1024.
// - Compare at BOTTOM gives constant low, at TOP constant high; inverted opposite.
// - Mode 8 or 9 selects phase and frequency correct PWM.
// - Counter runs up from 0x0000 to TOP then back down to BOTTOM.
// - Mode 8 takes TOP from capture value, mode 9 from compare A.
// - Counter shows TOP for exactly one tick before decrementing.
// - A counter match with a channel compare sets that channel's flag.
// - Frequency correct mode loads compares and sets overflow at BOTTOM.
// - When compare A or capture defines TOP, its flag sets at TOP.
// - One synchronous clock; the tick only enables counting and updates.
// - Modes 1, 2, 3, 10, 11 select phase correct PWM with their TOP.
// - Phase correct mode sets overflow each time the counter reaches BOTTOM.
// - Compare writes go to buffers; active compares change only at update points.
module dspt_timer (
    input  wire logic                      mclk,
    input  wire logic                      reset,
    input  wire dspt_pkg::dspt_axi_req_type axiReq,
    output dspt_pkg::dspt_axi_rsp_type      axiRsp,
    output logic [1:0]                      pinOut,
    output logic [1:0]                      pinOe
);

    typedef struct packed {
        logic                            awHave;
        logic [dspt_pkg::AXI_AW-1:0]     awAddr;
        logic                            wHave;
        logic [dspt_pkg::AXI_DW-1:0]     wData;
        logic [3:0]                      wStrb;
        logic                            bValid;
        logic [1:0]                      bResp;
        logic                            rValid;
        logic [dspt_pkg::AXI_DW-1:0]     rData;
        logic [1:0]                      rResp;
        dspt_pkg::dspt_ctrl_type         ctrl;
        logic [dspt_pkg::CNT_W-1:0]      count;
        logic                            down;
        logic [1:0][dspt_pkg::CNT_W-1:0] bufCmp;
        logic [1:0][dspt_pkg::CNT_W-1:0] actCmp;
        logic [dspt_pkg::CNT_W-1:0]      capture;
        logic [dspt_pkg::FLAG_N-1:0]     flags;
        logic [1:0]                      wave;
    } dspt_state_type;

    dspt_state_type s_q;
    dspt_state_type s_d;

    logic                            timerTick;
    logic                            dualMode;
    logic                            freqMode;
    logic [dspt_pkg::CNT_W-1:0]      topValue;
    logic                            atTop;
    logic                            atBottom;
    logic [1:0]                      match;
    logic                            doWrite;
    logic                            countWrite;
    logic [dspt_pkg::AXI_DW-1:0]     wMerged;
    logic [dspt_pkg::AXI_DW-1:0]     readWord;
    logic                            readHit;
    logic                            writeHit;
    logic [dspt_pkg::FLAG_N-1:0]     flagSet;
    logic [dspt_pkg::FLAG_N-1:0]     flagClr;

    // Byte-lane merge of a write into the old register word
    function automatic logic [31:0] mergeBytes(input logic [31:0] oldWord,
                                               input logic [31:0] newWord,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = oldWord;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                res[8*b +: 8] = newWord[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Tick enable; everything below stays on mclk
    dspt_prescaler #(
        .PRE_W     (dspt_pkg::PRE_BITS1024)
    ) dspt_prescaler_i (
        .mclk      (mclk),
        .reset     (reset),
        .clockSel  (s_q.ctrl.clockSel),
        .timerTick (timerTick)
    );

    // Mode decode and TOP selection
    always_comb
    begin
        dualMode = 1'b1;
        freqMode = 1'b0;
        topValue = dspt_pkg::TOP_FIX8;
        unique case (s_q.ctrl.waveMode)
            dspt_pkg::MODE_PC_FIX8:  topValue = dspt_pkg::TOP_FIX8;
            dspt_pkg::MODE_PC_FIX9:  topValue = dspt_pkg::TOP_FIX9;
            dspt_pkg::MODE_PC_FIX10: topValue = dspt_pkg::TOP_FIX10;
            dspt_pkg::MODE_PC_CAP:   topValue = s_q.capture;
            dspt_pkg::MODE_PC_CMP:   topValue = s_q.actCmp[0];
            dspt_pkg::MODE_PFC_CAP:
            begin
                freqMode = 1'b1;
                topValue = s_q.capture;
            end
            dspt_pkg::MODE_PFC_CMP:
            begin
                freqMode = 1'b1;
                topValue = s_q.actCmp[0];
            end
            default: dualMode = 1'b0;
        endcase
    end

    assign atTop    = (s_q.count == topValue);
    assign atBottom = (s_q.count == dspt_pkg::BOTTOM);

    // Per-channel match and pin drive; a compare above TOP never matches
    for (genvar i = 0; i < 2; i++)
    begin : g_ch
        assign match[i] = (s_q.count == s_q.actCmp[i]) && (s_q.actCmp[i] <= topValue);
        assign pinOe[i] = s_q.ctrl.pinDir[i] && s_q.ctrl.outAction[i][1];
        assign pinOut[i] = s_q.wave[i] && pinOe[i];
    end

    // Bus handshakes come straight from state
    assign axiRsp.awready = !s_q.awHave && !s_q.bValid;
    assign axiRsp.wready  = !s_q.wHave && !s_q.bValid;
    assign axiRsp.bvalid  = s_q.bValid;
    assign axiRsp.bresp   = s_q.bResp;
    // A read is refused while a write commits, since both share the decode
    assign axiRsp.arready = !s_q.rValid && !doWrite;
    assign axiRsp.rvalid  = s_q.rValid;
    assign axiRsp.rdata   = s_q.rData;
    assign axiRsp.rresp   = s_q.rResp;

    assign doWrite    = s_q.awHave && s_q.wHave && !s_q.bValid;
    assign wMerged    = mergeBytes(readWord, s_q.wData, s_q.wStrb);
    assign countWrite = doWrite && ({s_q.awAddr[7:2], 2'b00} == dspt_pkg::OFS_COUNT);

    // Read decode; also serves as the old word for byte-lane writes
    always_comb
    begin
        logic [dspt_pkg::AXI_AW-1:0] addr;
        addr = doWrite ? {s_q.awAddr[7:2], 2'b00} : {axiReq.araddr[7:2], 2'b00};
        readWord = '0;
        readHit  = 1'b1;
        unique case (addr)
            dspt_pkg::OFS_CTRL:    readWord = s_q.ctrl;
            dspt_pkg::OFS_COUNT:   readWord[15:0] = s_q.count;
            dspt_pkg::OFS_CMP_A:   readWord[15:0] = s_q.bufCmp[0];
            dspt_pkg::OFS_CMP_B:   readWord[15:0] = s_q.bufCmp[1];
            dspt_pkg::OFS_CAPTURE: readWord[15:0] = s_q.capture;
            dspt_pkg::OFS_FLAGS:   readWord[dspt_pkg::FLAG_N-1:0] = s_q.flags;
            dspt_pkg::OFS_STATUS:  readWord[2:0] = {s_q.wave, s_q.down};
            default:               readHit = 1'b0;
        endcase
        writeHit = readHit && (addr != dspt_pkg::OFS_STATUS);
    end

    // Next state: bus slave, counter, compare units and flags
    always_comb
    begin
        s_d     = s_q;
        flagSet = '0;
        flagClr = '0;

        // Address and data are taken in either order, response follows both
        if (axiReq.awvalid && !s_q.awHave && !s_q.bValid)
        begin
            s_d.awHave = 1'b1;
            s_d.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && !s_q.wHave && !s_q.bValid)
        begin
            s_d.wHave = 1'b1;
            s_d.wData = axiReq.wdata;
            s_d.wStrb = axiReq.wstrb;
        end
        if (s_q.bValid && axiReq.bready)
        begin
            s_d.bValid = 1'b0;
        end
        if (doWrite)
        begin
            s_d.awHave = 1'b0;
            s_d.wHave  = 1'b0;
            s_d.bValid = 1'b1;
            s_d.bResp  = writeHit ? dspt_pkg::RESP_OKAY : dspt_pkg::RESP_SLVERR;
        end

        // Reads wait while a write is being committed so the decode is shared
        if (s_q.rValid)
        begin
            if (axiReq.rready)
            begin
                s_d.rValid = 1'b0;
            end
        end
        else if (axiReq.arvalid && !doWrite)
        begin
            s_d.rValid = 1'b1;
            s_d.rData  = readWord;
            s_d.rResp  = readHit ? dspt_pkg::RESP_OKAY : dspt_pkg::RESP_SLVERR;
        end

        // Counting only on a tick and only in a dual-slope mode
        if (timerTick && dualMode)
        begin
            if (!s_q.down)
            begin
                if (atTop)
                begin
                    s_d.down  = 1'b1;
                    s_d.count = s_q.count - dspt_pkg::CNT_ONE;
                end
                else
                begin
                    s_d.count = s_q.count + dspt_pkg::CNT_ONE;
                end
            end
            else if (atBottom)
            begin
                s_d.down  = 1'b0;
                s_d.count = s_q.count + dspt_pkg::CNT_ONE;
            end
            else
            begin
                s_d.count = s_q.count - dspt_pkg::CNT_ONE;
            end

            // Update point: TOP for phase correct, BOTTOM for frequency correct
            if ((atTop && !freqMode) || (atBottom && freqMode))
            begin
                s_d.actCmp = s_q.bufCmp;
            end
            if (atBottom)
            begin
                flagSet[dspt_pkg::FLAG_OVF] = 1'b1;
            end
            if (atTop && (s_q.ctrl.waveMode == dspt_pkg::MODE_PFC_CAP
                          || s_q.ctrl.waveMode == dspt_pkg::MODE_PC_CAP))
            begin
                flagSet[dspt_pkg::FLAG_CAP] = 1'b1;
            end
            if (atTop && (s_q.ctrl.waveMode == dspt_pkg::MODE_PFC_CMP
                          || s_q.ctrl.waveMode == dspt_pkg::MODE_PC_CMP))
            begin
                flagSet[dspt_pkg::FLAG_CMPA] = 1'b1;
            end

            // Compare units; turning points force the extreme duty levels
            for (int i = 0; i < 2; i++)
            begin
                if (match[i])
                begin
                    flagSet[dspt_pkg::FLAG_CMPA + i] = 1'b1;
                    if (s_q.ctrl.outAction[i][1])
                    begin
                        // Up match and BOTTOM drive action bit 0, down match and TOP its inverse
                        if (atTop || (s_q.down && !atBottom))
                        begin
                            s_d.wave[i] = !s_q.ctrl.outAction[i][0];
                        end
                        else
                        begin
                            s_d.wave[i] = s_q.ctrl.outAction[i][0];
                        end
                    end
                end
            end
        end

        // Register writes; a counter write overrides the tick step
        if (doWrite && writeHit)
        begin
            unique case ({s_q.awAddr[7:2], 2'b00})
                dspt_pkg::OFS_CTRL:    s_d.ctrl = wMerged;
                dspt_pkg::OFS_COUNT:   s_d.count = wMerged[15:0];
                dspt_pkg::OFS_CMP_A:   s_d.bufCmp[0] = wMerged[15:0];
                dspt_pkg::OFS_CMP_B:   s_d.bufCmp[1] = wMerged[15:0];
                dspt_pkg::OFS_CAPTURE: s_d.capture = wMerged[15:0];
                dspt_pkg::OFS_FLAGS:
                begin
                    flagClr = s_q.wData[dspt_pkg::FLAG_N-1:0] & {dspt_pkg::FLAG_N{s_q.wStrb[0]}};
                end
                default:               s_d.ctrl = s_q.ctrl;
            endcase
        end

        // Write-one-to-clear; a flag set in the same cycle survives
        s_d.flags = (s_q.flags & ~flagClr) | flagSet;
    end

    // Single register stage for the whole state
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            s_q      <= '0;
            s_q.ctrl <= dspt_pkg::CTRL_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Checks on the counter sequence, updates, flags and waveform
    a_bottom_turn: assert property (@(posedge mclk) disable iff (reset)
        timerTick && dualMode && s_q.down && atBottom && !countWrite
        |=> !s_q.down && s_q.count == dspt_pkg::CNT_ONE)
        else $error("counter did not turn upward at bottom");

    a_top_hold: assert property (@(posedge mclk) disable iff (reset)
        timerTick && dualMode && !s_q.down && atTop && !countWrite
        |=> s_q.down && s_q.count == $past(s_q.count) - dspt_pkg::CNT_ONE)
        else $error("counter did not turn downward after top");

    a_overflow_set: assert property (@(posedge mclk) disable iff (reset)
        timerTick && dualMode && atBottom |=> s_q.flags[dspt_pkg::FLAG_OVF])
        else $error("overflow flag missing at bottom");

    a_match_flag: assert property (@(posedge mclk) disable iff (reset)
        timerTick && dualMode && match[1] ##1 !$past(flagClr[dspt_pkg::FLAG_CMPB])
        |-> s_q.flags[dspt_pkg::FLAG_CMPB])
        else $error("compare flag missing after match");

    a_top_update: assert property (@(posedge mclk) disable iff (reset)
        timerTick && dualMode && !freqMode && atTop
        |=> s_q.actCmp[0] == $past(s_q.bufCmp[0]))
        else $error("compare not loaded at top in phase correct mode");

    a_bottom_update: assert property (@(posedge mclk) disable iff (reset)
        timerTick && freqMode && atBottom
        |=> s_q.actCmp[1] == $past(s_q.bufCmp[1]) && s_q.flags[dspt_pkg::FLAG_OVF])
        else $error("compare or overflow not updated at bottom");

    a_active_hold: assert property (@(posedge mclk) disable iff (reset)
        !timerTick |=> $stable(s_q.actCmp))
        else $error("active compare changed without a tick");

    a_low_stays: assert property (@(posedge mclk) disable iff (reset)
        dualMode && s_q.ctrl.outAction[1] == dspt_pkg::ACT_NONINV
        && s_q.actCmp[1] == dspt_pkg::BOTTOM && !s_q.wave[1]
        && $stable(s_q.ctrl) |=> !s_q.wave[1])
        else $error("output left low level with compare at bottom");

    a_up_clear: assert property (@(posedge mclk) disable iff (reset)
        timerTick && dualMode && match[1] && !s_q.down && !atTop && !atBottom
        && s_q.ctrl.outAction[1] == dspt_pkg::ACT_NONINV |=> !s_q.wave[1])
        else $error("non-inverted output not cleared on up match");

    a_inv_set: assert property (@(posedge mclk) disable iff (reset)
        timerTick && dualMode && match[0] && !s_q.down && !atTop && !atBottom
        && s_q.ctrl.outAction[0] == dspt_pkg::ACT_INV |=> s_q.wave[0])
        else $error("inverted output not set on up match");

    a_div8_gap: assert property (@(posedge mclk) disable iff (reset)
        timerTick && s_q.ctrl.clockSel == dspt_pkg::CS_DIV8
        |=> (!timerTick || s_q.ctrl.clockSel != dspt_pkg::CS_DIV8)[*7])
        else $error("divide-by-8 tick came too early");

endmodule

// ### testbench/dspt_timer_tb_top.sv
// Self-checking bench for the dual-slope PWM timer, driven over AXI4-Lite
`timescale 1ns/10ps
module dspt_timer_tb_top;
    logic                       mclk;
    logic                       reset;
    dspt_pkg::dspt_axi_req_type req;
    dspt_pkg::dspt_axi_rsp_type rsp;
    logic [1:0]                 pinOut;
    logic [1:0]                 pinOe;
    logic [33:0]                expQ [$];
    int                         nMismatch;
    int                         cmpCount;
    logic [3:0]                 modeList [7] = '{4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb};

    dspt_timer dspt_timer_i (
        .mclk   (mclk),
        .reset  (reset),
        .axiReq (req),
        .axiRsp (rsp),
        .pinOut (pinOut),
        .pinOe  (pinOe)
    );

    // 200 MHz clock
    initial mclk = 1'b0;
    always #2.5 mclk = ~mclk;

    // Pseudo-random source for compare values
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        cmpCount++;
        if (got !== exp)
        begin
            nMismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tallyAndFinish();
        $display("Compares %0d mismatches %0d", cmpCount, nMismatch);
        if (nMismatch == 0 && cmpCount > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Ready is sampled at the falling edge, so the decision never races the rising edge
    task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ta, tw, tb;
        @(posedge mclk);
        expQ.push_back({r, 32'h0});
        req.awaddr  <= a;
        req.wdata   <= d;
        req.wstrb   <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        do
        begin
            @(negedge mclk);
            ta = req.awvalid & rsp.awready;
            tw = req.wvalid & rsp.wready;
            tb = rsp.bvalid;
            @(posedge mclk);
            if (ta) req.awvalid <= 1'b0;
            if (tw) req.wvalid <= 1'b0;
        end while (!tb);
        req.bready <= 1'b0;
    endtask

    task automatic axiRd(input logic [7:0] a, input logic [33:0] e);
        logic ta, tr;
        @(posedge mclk);
        expQ.push_back(e);
        req.araddr  <= a;
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        do
        begin
            @(negedge mclk);
            ta = req.arvalid & rsp.arready;
            tr = rsp.rvalid;
            @(posedge mclk);
            if (ta) req.arvalid <= 1'b0;
        end while (!tr);
        req.rready <= 1'b0;
    endtask

    task automatic setCtrl(input logic [3:0] m, input logic [2:0] cs, input logic [1:0] dir);
        dspt_pkg::dspt_ctrl_type c;
        c = dspt_pkg::CTRL_RESET;
        c.waveMode     = m;
        c.clockSel     = cs;
        c.outAction[0] = dspt_pkg::ACT_INV;
        c.outAction[1] = dspt_pkg::ACT_NONINV;
        c.pinDir       = dir;
        axiWr(dspt_pkg::OFS_CTRL, 32'(c), dspt_pkg::RESP_OKAY);
    endtask

    // Counting high cycles over whole periods makes the check independent of phase
    task automatic measure(input int n, output int ha, output int hb);
        ha = 0;
        hb = 0;
        repeat (n)
        begin
            @(negedge mclk);
            ha += int'(pinOut[0] === 1'b1);
            hb += int'(pinOut[1] === 1'b1);
        end
    endtask

    // Bus answers are matched against the oldest note in the queue
    always @(negedge mclk)
    begin
        if (rsp.rvalid && req.rready)
            chk({rsp.rresp, rsp.rdata}, expQ.pop_front());
        if (rsp.bvalid && req.bready)
            chk({rsp.bresp, 32'h0}, expQ.pop_front());
    end

    // Watchdog sized well above the longest mode sweep
    initial
    begin
        repeat (60000) @(posedge mclk);
        nMismatch++;
        tallyAndFinish();
    end

    // Main sequence: reset values, then every dual-slope mode in turn
    initial
    begin
        int t, ca, cb, ha, hb, n;
        logic [3:0]  m;
        logic [31:0] rnd;
        rnd   = 32'hf0e391a4;
        reset = 1'b1;
        req   = '0;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        axiRd(dspt_pkg::OFS_CTRL, 34'h0);
        axiRd(dspt_pkg::OFS_FLAGS, 34'h0);
        axiRd(8'h20, {dspt_pkg::RESP_SLVERR, 32'h0});
        axiWr(dspt_pkg::OFS_STATUS, 32'h0, dspt_pkg::RESP_SLVERR);
        axiRd(dspt_pkg::OFS_STATUS, 34'h0);
        for (int i = 0; i < 7; i++)
        begin
            m   = modeList[i];
            t   = (m == 4'h1) ? 255 : (m == 4'h2) ? 511 : (m == 4'h3) ? 1023 :
                  (m == 4'h8 || m == 4'ha) ? 10 : 12;
            ca  = (m == 4'h9 || m == 4'hb) ? 12 : 3;
            rnd = lfsr(rnd);
            cb  = (i == 0) ? 0 : (i == 1) ? t : int'(rnd[15:0]) % (t + 1);
            setCtrl(m, dspt_pkg::CS_STOP, 2'b11);
            axiWr(dspt_pkg::OFS_COUNT, 32'h0, dspt_pkg::RESP_OKAY);
            axiWr(dspt_pkg::OFS_CAPTURE, 32'h0000000a, dspt_pkg::RESP_OKAY);
            axiWr(dspt_pkg::OFS_CMP_A, 32'(ca), dspt_pkg::RESP_OKAY);
            axiWr(dspt_pkg::OFS_CMP_B, 32'(cb), dspt_pkg::RESP_OKAY);
            axiRd(dspt_pkg::OFS_CMP_B, {dspt_pkg::RESP_OKAY, 32'(cb)});
            setCtrl(m, dspt_pkg::CS_DIV1, 2'b11);
            repeat (4 * t) @(posedge mclk);
            measure(4 * t, ha, hb);
            chk(34'(ha), 34'(4 * t - 4 * ca));
            chk(34'(hb), 34'(4 * cb));
            chk(34'(pinOe), 34'h3);
            setCtrl(m, dspt_pkg::CS_STOP, 2'b11);
            axiRd(dspt_pkg::OFS_FLAGS, 34'((m == 4'h8 || m == 4'ha) ? 4'hf : 4'h7));
            axiWr(dspt_pkg::OFS_FLAGS, 32'h0000000f, dspt_pkg::RESP_OKAY);
            axiRd(dspt_pkg::OFS_FLAGS, 34'h0);
        end
        // Slow ticks: each ratio stretches the same TOP-3 wave by its divisor
        axiWr(dspt_pkg::OFS_CAPTURE, 32'h00000003, dspt_pkg::RESP_OKAY);
        axiWr(dspt_pkg::OFS_CMP_A, 32'h00000001, dspt_pkg::RESP_OKAY);
        axiWr(dspt_pkg::OFS_CMP_B, 32'h00000002, dspt_pkg::RESP_OKAY);
        for (int k = 2; k < 6; k++)
        begin
            n = (k == 2) ? 8 : (k == 3) ? 64 : (k == 4) ? 256 : 1024;
            setCtrl(4'h8, dspt_pkg::CS_STOP, 2'b11);
            axiWr(dspt_pkg::OFS_COUNT, 32'h0, dspt_pkg::RESP_OKAY);
            axiRd(dspt_pkg::OFS_COUNT, 34'h0);
            setCtrl(4'h8, 3'(k), 2'b11);
            // One period is 6 ticks; 7 ticks of warm-up cover the tick phase and first matches
            repeat (7 * n) @(posedge mclk);
            measure(6 * n, ha, hb);
            chk(34'(ha), 34'(4 * n));
            chk(34'(hb), 34'(4 * n));
        end
        // Direction bits off: the pins must stay quiet while the wave runs
        setCtrl(4'h8, dspt_pkg::CS_DIV1, 2'b00);
        measure(40, ha, hb);
        chk(34'(ha + hb), 34'h0);
        chk(34'(pinOe), 34'h0);
        tallyAndFinish();
    end
endmodule
